//--- shared/atp_defines.vh
// register offsets, field positions, reset values and timing for the trigger/pacer counter block
`ifndef ATP_DEFINES_VH
`define ATP_DEFINES_VH

// register byte offsets
`define ATP_CTRL_ADDR       12'h000
`define ATP_GP_DIV_ADDR     12'h004
`define ATP_PACER_DIV_ADDR  12'h008
`define ATP_GP_COUNT_ADDR   12'h00c
`define ATP_STATUS_ADDR     12'h010
`define ATP_CONV_CNT_ADDR   12'h014

// control fields
`define ATP_CTRL_TRG_SRC    0
`define ATP_CTRL_PACER_EN   1
`define ATP_CTRL_PACER_OE   2
`define ATP_CTRL_GP_CLK_SEL 3
`define ATP_CTRL_GP_MODE    4
`define ATP_CTRL_GP_EN      5
`define ATP_CTRL_W          6
`define ATP_CTRL_RST        6'h00

// status fields
`define ATP_STAT_GP_ARMED   0
`define ATP_STAT_PACER_LVL  1
`define ATP_STAT_EXT_EN     2
`define ATP_STAT_GP_OUT     3

// reset values of the dividers
`define ATP_GP_DIV_RST      16'h0002
`define ATP_PACER_DIV_RST   32'h0000_0002

// timebase rates in kHz, from the 125 MHz pclk
`define ATP_PCLK_KHZ        125000
`define ATP_TB10_KHZ        10000
`define ATP_TB1_KHZ         1000

`endif

//--- core/atp_sync_edge.v
// three-stage synchroniser with agreeing-stage rising edge detect
`timescale 1ns/1ns
module atp_sync_edge
(
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	// asynchronous pin
	input  wire pin_in,
	// synchronised level and rising edge pulse
	output reg  level_r,
	output wire rise
);

reg s1_r;
reg s2_r;
reg s3_r;

// a change counts once stages two and three agree
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		s1_r    <= 1'b0;
		s2_r    <= 1'b0;
		s3_r    <= 1'b0;
		level_r <= 1'b0;
	end
	else
	begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
		if (s2_r == s3_r)
			level_r <= s3_r;
	end
end

// one pulse per qualified rising edge
assign rise = (s2_r == s3_r) && s3_r && !level_r;

endmodule // atp_sync_edge

//--- core/atp_trigger_pacer.v
// trigger, pacer and general-purpose counter logic with apb registers
`timescale 1ns/1ns
`include "atp_defines.vh"

module atp_trigger_pacer
#(
	parameter GP_W    = 16,
	parameter PACER_W = 32
)
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// field pins
	input  wire        gp_counter_clock_in,
	input  wire        gp_counter_gate_in,
	input  wire        ext_trigger_enable_in,
	input  wire        ext_conversion_trigger_in,
	output reg         gp_counter_out,
	output reg         pacer_out,
	// converter start
	output reg         conv_start
);

localparam integer TB10_DIV = `ATP_PCLK_KHZ / `ATP_TB10_KHZ;
localparam integer TB1_DIV  = `ATP_PCLK_KHZ / `ATP_TB1_KHZ;

// register file
reg  [`ATP_CTRL_W-1:0] ctrl_r;
reg  [GP_W-1:0]        gp_div_r;
reg  [PACER_W-1:0]     pacer_div_r;
reg  [GP_W-1:0]        gp_count_r;
reg  [31:0]            conv_cnt_r;

// timebases
reg  [7:0]             tb10_acc_r;
reg  [10:0]            tb1_acc_r;
reg                    tb10_tick_r;
reg                    tb1_tick_r;

// pacer chain and gp divider
reg  [GP_W-1:0]        pc_lo_r;
reg  [PACER_W-GP_W-1:0] pc_hi_r;
reg                    pacer_lvl_r;
reg                    pacer_lvl_d_r;
reg  [GP_W-1:0]        gp_div_cnt_r;
reg                    gp_armed_r;

wire                   wr_en;
wire                   rd_en;
wire                   addr_ok;
wire                   ext_clk_rise;
wire                   gate_rise;
wire                   trg_en_lvl;
wire                   ext_conversion_trigger_in_rise;
wire                   gp_tick;
wire                   pacer_rise;
wire                   ext_start;

atp_sync_edge u_sync_clk
(
	.pclk    (pclk),
	.presetn (presetn),
	.pin_in  (gp_counter_clock_in),
	.level_r (),
	.rise    (ext_clk_rise)
);

atp_sync_edge u_sync_gate
(
	.pclk    (pclk),
	.presetn (presetn),
	.pin_in  (gp_counter_gate_in),
	.level_r (),
	.rise    (gate_rise)
);

atp_sync_edge u_sync_en
(
	.pclk    (pclk),
	.presetn (presetn),
	.pin_in  (ext_trigger_enable_in),
	.level_r (trg_en_lvl),
	.rise    ()
);

atp_sync_edge u_sync_trg
(
	.pclk    (pclk),
	.presetn (presetn),
	.pin_in  (ext_conversion_trigger_in),
	.level_r (),
	.rise    (ext_conversion_trigger_in_rise)
);

// apb decode, zero wait states
assign pready  = 1'b1;
assign addr_ok = (paddr == `ATP_CTRL_ADDR) || (paddr == `ATP_GP_DIV_ADDR) ||
                 (paddr == `ATP_PACER_DIV_ADDR) || (paddr == `ATP_GP_COUNT_ADDR) ||
                 (paddr == `ATP_STATUS_ADDR) || (paddr == `ATP_CONV_CNT_ADDR);
assign pslverr = psel && penable && !addr_ok;
assign wr_en   = psel && penable && pwrite;
assign rd_en   = psel && !penable && !pwrite;

// common 10 MHz and 1 MHz ticks
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		tb10_acc_r  <= 8'h00;
		tb1_acc_r   <= 11'h000;
		tb10_tick_r <= 1'b0;
		tb1_tick_r  <= 1'b0;
	end
	else
	begin
		tb10_tick_r <= (tb10_acc_r == TB10_DIV[7:0] - 8'h01);
		tb1_tick_r  <= (tb1_acc_r == TB1_DIV[10:0] - 11'h001);
		tb10_acc_r  <= (tb10_acc_r == TB10_DIV[7:0] - 8'h01) ? 8'h00 : tb10_acc_r + 8'h01;
		tb1_acc_r   <= (tb1_acc_r == TB1_DIV[10:0] - 11'h001) ? 11'h000 : tb1_acc_r + 11'h001;
	end
end

// gp counter clock: external pin or internal 1 MHz
assign gp_tick = ctrl_r[`ATP_CTRL_GP_CLK_SEL] ? tb1_tick_r : ext_clk_rise;

// pacer rising edge and gated external edge
assign pacer_rise = pacer_lvl_r && !pacer_lvl_d_r;
assign ext_start  = ext_conversion_trigger_in_rise && trg_en_lvl;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ctrl_r         <= `ATP_CTRL_RST;
		gp_div_r       <= `ATP_GP_DIV_RST;
		pacer_div_r    <= `ATP_PACER_DIV_RST;
		pc_lo_r        <= {GP_W{1'b0}};
		pc_hi_r        <= {(PACER_W-GP_W){1'b0}};
		pacer_lvl_r    <= 1'b0;
		pacer_lvl_d_r  <= 1'b0;
		pacer_out      <= 1'b0;
		conv_start     <= 1'b0;
		conv_cnt_r     <= 32'h0000_0000;
		gp_div_cnt_r   <= {GP_W{1'b0}};
		gp_count_r     <= {GP_W{1'b0}};
		gp_armed_r     <= 1'b0;
		gp_counter_out <= 1'b0;
	end
	else
	begin
		// register writes
		if (wr_en && paddr == `ATP_CTRL_ADDR)
			ctrl_r <= pwdata[`ATP_CTRL_W-1:0];
		if (wr_en && paddr == `ATP_GP_DIV_ADDR)
			gp_div_r <= pwdata[GP_W-1:0];
		if (wr_en && paddr == `ATP_PACER_DIV_ADDR)
			pacer_div_r <= pwdata[PACER_W-1:0];

		// cascaded 32-bit pacer: low half carries into high half
		if (!ctrl_r[`ATP_CTRL_PACER_EN])
		begin
			pc_lo_r     <= {GP_W{1'b0}};
			pc_hi_r     <= {(PACER_W-GP_W){1'b0}};
			pacer_lvl_r <= 1'b0;
		end
		else if (tb10_tick_r)
		begin
			if ({pc_hi_r, pc_lo_r} >= pacer_div_r - {{(PACER_W-1){1'b0}}, 1'b1})
			begin
				pc_lo_r     <= {GP_W{1'b0}};
				pc_hi_r     <= {(PACER_W-GP_W){1'b0}};
				pacer_lvl_r <= 1'b1;
			end
			else
			begin
				pc_lo_r <= pc_lo_r + {{(GP_W-1){1'b0}}, 1'b1};
				if (pc_lo_r == {GP_W{1'b1}})
					pc_hi_r <= pc_hi_r + {{(PACER_W-GP_W-1){1'b0}}, 1'b1};
				if ({pc_hi_r, pc_lo_r} >= {1'b0, pacer_div_r[PACER_W-1:1]})
					pacer_lvl_r <= 1'b0;
			end
		end
		pacer_lvl_d_r <= pacer_lvl_r;
		pacer_out     <= pacer_lvl_r && ctrl_r[`ATP_CTRL_PACER_OE];

		// one conversion start per edge of the selected source
		conv_start <= ctrl_r[`ATP_CTRL_TRG_SRC] ? ext_start : pacer_rise;
		if (conv_start)
			conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
		// a start in the clearing cycle is still counted
		if (wr_en && paddr == `ATP_CONV_CNT_ADDR)
			conv_cnt_r <= {31'h0000_0000, conv_start};

		// general-purpose counter
		if (!ctrl_r[`ATP_CTRL_GP_EN])
		begin
			gp_armed_r     <= 1'b0;
			gp_div_cnt_r   <= {GP_W{1'b0}};
			gp_counter_out <= 1'b0;
		end
		else if (ctrl_r[`ATP_CTRL_GP_MODE])
		begin
			// pulse mode: square wave at clock / divisor
			if (gp_tick)
			begin
				if (gp_div_cnt_r >= (gp_div_r >> 1) - {{(GP_W-1){1'b0}}, 1'b1})
				begin
					gp_div_cnt_r   <= {GP_W{1'b0}};
					gp_counter_out <= !gp_counter_out;
				end
				else
					gp_div_cnt_r <= gp_div_cnt_r + {{(GP_W-1){1'b0}}, 1'b1};
			end
		end
		else
		begin
			// event mode: arm on gate edge, then count clock edges
			if (gate_rise)
				gp_armed_r <= 1'b1;
			if (gp_armed_r && gp_tick)
				gp_count_r <= gp_count_r + {{(GP_W-1){1'b0}}, 1'b1};
			gp_counter_out <= gp_armed_r;
		end
		if (wr_en && paddr == `ATP_GP_COUNT_ADDR)
			gp_count_r <= pwdata[GP_W-1:0];
	end
end

// read data registered in setup phase
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h0000_0000;
	else if (rd_en)
	begin
		case (paddr)
			`ATP_CTRL_ADDR:      prdata <= {{(32-`ATP_CTRL_W){1'b0}}, ctrl_r};
			`ATP_GP_DIV_ADDR:    prdata <= {{(32-GP_W){1'b0}}, gp_div_r};
			`ATP_PACER_DIV_ADDR: prdata <= pacer_div_r;
			`ATP_GP_COUNT_ADDR:  prdata <= {{(32-GP_W){1'b0}}, gp_count_r};
			`ATP_STATUS_ADDR:    prdata <= {28'h0000000, gp_counter_out, trg_en_lvl,
			                               pacer_lvl_r, gp_armed_r};
			`ATP_CONV_CNT_ADDR:  prdata <= conv_cnt_r;
			default:             prdata <= 32'h0000_0000;
		endcase
	end
end

endmodule // atp_trigger_pacer

//--- sim/atp_assertions.sv
// checker for trigger, pacer and counter port behaviour
`timescale 1ns/1ns
module atp_chk
(
	// clock and reset
	input wire        pclk,
	input wire        presetn,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	// pins
	input wire        ext_trigger_enable_in,
	input wire        ext_conversion_trigger_in,
	input wire        gp_counter_gate_in,
	input wire        gp_counter_out,
	input wire        pacer_out,
	input wire        conv_start
);
	logic [5:0] ctrl_r;
	logic [3:0] q_r;
	logic [3:0] lo_r;
	logic [3:0] hi_r;
	wire        wr = psel && penable && pwrite && paddr == 12'h000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// control snoop and settle counters
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_r <= 6'h00;
			q_r <= 4'h0;
			lo_r <= 4'h0;
			hi_r <= 4'h0;
		end
		else
		begin
			ctrl_r <= wr ? pwdata[5:0] : ctrl_r;
			q_r <= wr ? 4'h0 : q_r + {3'h0, q_r != 4'hf};
			lo_r <= ext_trigger_enable_in ? 4'h0 : lo_r + {3'h0, lo_r != 4'hf};
			hi_r <= !ext_trigger_enable_in ? 4'h0 : hi_r + {3'h0, hi_r != 4'hf};
		end
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	a_pacer_start: assert property (!ctrl_r[0] && ctrl_r[1] && q_r > 4 && $rose(pacer_out)
		|-> ##[0:2] conv_start) else $error("pacer edge without start");
	a_pacer_hidden: assert property (!ctrl_r[2] && q_r > 1 |-> !pacer_out)
		else $error("pacer pin driven while off");
	a_ext_off: assert property (ctrl_r[0] && lo_r > 7 |-> !conv_start)
		else $error("start while gate low");
	a_ext_start: assert property (ctrl_r[0] && hi_r > 7 && q_r > 7
		&& $rose(ext_conversion_trigger_in) |-> ##[2:6] conv_start) else $error("edge missed");
	a_src_idle: assert property (!ctrl_r[0] && !ctrl_r[1] && q_r > 7 |-> !conv_start)
		else $error("start from unselected source");
	a_gp_idle: assert property (ctrl_r[5:4] == 2'b00 && q_r > 7 |-> !gp_counter_out)
		else $error("counter out while off");
	a_gate_arms: assert property (ctrl_r[5:4] == 2'b10 && q_r > 7
		&& $rose(gp_counter_gate_in) |-> ##[2:6] gp_counter_out) else $error("gate not armed");
endmodule // atp_chk
bind atp_trigger_pacer atp_chk u_chk
(
	.pclk                      (pclk),
	.presetn                   (presetn),
	.psel                      (psel),
	.penable                   (penable),
	.pwrite                    (pwrite),
	.paddr                     (paddr),
	.pwdata                    (pwdata),
	.ext_trigger_enable_in     (ext_trigger_enable_in),
	.ext_conversion_trigger_in (ext_conversion_trigger_in),
	.gp_counter_gate_in        (gp_counter_gate_in),
	.gp_counter_out            (gp_counter_out),
	.pacer_out                 (pacer_out),
	.conv_start                (conv_start)
);

//--- sim/atp_field_model.sv
// field wiring model: trigger, gate and counter pins
`timescale 1ns/1ns
module atp_field_model
(
	// clock
	input  wire pclk,
	// pins toward the block
	output wire ext_conversion_trigger_in,
	output wire ext_trigger_enable_in,
	output wire gp_counter_clock_in,
	output wire gp_counter_gate_in
);
	logic [3:0] pin_r = 4'h0;
	assign {gp_counter_gate_in, gp_counter_clock_in} = pin_r[3:2];
	assign {ext_trigger_enable_in, ext_conversion_trigger_in} = pin_r[1:0];
	// static trigger enable level, then settle
	task lvl(input logic v);
		pin_r[1] <= v;
		repeat (8) @(posedge pclk);
	endtask
	// n pulses, w cycles high and w low
	task pulse(input int i, input int n, input int w);
		repeat (n)
		begin
			pin_r[i] <= 1'b1;
			repeat (w) @(posedge pclk);
			pin_r[i] <= 1'b0;
			repeat (w) @(posedge pclk);
		end
	endtask
endmodule // atp_field_model

//--- sim/adc_trigger_pacer_counter_test.sv
// self-checking bench for the trigger, pacer and counter block
`timescale 1ns/1ns
module adc_trigger_pacer_counter_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pp, gp;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 0, rs = 60207, v;
	wire  [31:0] prdata;
	wire         pready, pslverr, gp_counter_out, pacer_out, conv_start;
	wire         ext_conversion_trigger_in, ext_trigger_enable_in;
	wire         gp_counter_clock_in, gp_counter_gate_in;
	int          error_cnt = 0, num_checks = 0, n, pr_cnt = 0, g_cnt = 0;
	logic [32:0] q[$];
	atp_trigger_pacer dut
	(
		.pclk                      (pclk),
		.presetn                   (presetn),
		.psel                      (psel),
		.penable                   (penable),
		.pwrite                    (pwrite),
		.paddr                     (paddr),
		.pwdata                    (pwdata),
		.prdata                    (prdata),
		.pready                    (pready),
		.pslverr                   (pslverr),
		.gp_counter_clock_in       (gp_counter_clock_in),
		.gp_counter_gate_in        (gp_counter_gate_in),
		.ext_trigger_enable_in     (ext_trigger_enable_in),
		.ext_conversion_trigger_in (ext_conversion_trigger_in),
		.gp_counter_out            (gp_counter_out),
		.pacer_out                 (pacer_out),
		.conv_start                (conv_start)
	);
	atp_field_model fm
	(
		.pclk                      (pclk),
		.ext_conversion_trigger_in (ext_conversion_trigger_in),
		.ext_trigger_enable_in     (ext_trigger_enable_in),
		.gp_counter_clock_in       (gp_counter_clock_in),
		.gp_counter_gate_in        (gp_counter_gate_in)
	);
	always #4 pclk = ~pclk;
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(string s, logic [32:0] seen, logic [32:0] e);
		num_checks++;
		if (seen !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", s, e, seen);
		end
	endtask
	task bus(logic w, logic [11:0] a, logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		@(posedge pclk) while (pready !== 1'b1) @(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(logic [11:0] a, logic [32:0] e);
		q.push_back(e);
		bus(0, a, 0);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// read results against oldest note
	always @(posedge pclk)
		if (psel && penable && !pwrite && pready)
			chk("read", {pslverr, prdata}, q.pop_front());
	// edge counters on pins
	always @(posedge pclk)
	begin
		pr_cnt += pacer_out && !pp;
		g_cnt += gp_counter_out && !gp;
		pp = pacer_out;
		gp = gp_counter_out;
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		report_and_stop;
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(12'h000, 0);
		rd(12'h004, 2);
		rd(12'h008, 2);
		rd(12'h018, 33'h1_0000_0000);
		bus(1, 12'h004, '1);
		rd(12'h004, 33'h0_0000_ffff);
		bus(1, 12'h008, '1);
		rd(12'h008, 33'h0_ffff_ffff);
		bus(1, 12'h014, 0);
		bus(1, 12'h000, 1);
		fm.lvl(1);
		n = xs() % 4 + 1;
		fm.pulse(0, n, 3);
		rd(12'h014, n);
		fm.lvl(0);
		fm.pulse(0, 3, 6);
		rd(12'h014, n);
		fm.lvl(1);
		bus(1, 12'h000, 0);
		fm.pulse(0, 3, 6);
		rd(12'h014, n);
		bus(1, 12'h014, 0);
		bus(1, 12'h008, 3);
		n = pr_cnt;
		bus(1, 12'h000, 6);
		repeat (400) @(posedge pclk);
		bus(1, 12'h000, 0);
		repeat (8) @(posedge pclk);
		chk("pacer_rate", pr_cnt - n inside {[9:12]}, 1);
		rd(12'h014, pr_cnt - n);
		bus(1, 12'h000, 32);
		v = xs() & 32'h0000_0fff;
		bus(1, 12'h00c, v);
		fm.pulse(2, 2, 3);
		fm.pulse(3, 1, 4);
		n = xs() % 5 + 2;
		fm.pulse(2, n, 3);
		rd(12'h00c, v + n);
		rd(12'h010, 33'h0_0000_000d);
		bus(1, 12'h004, 2);
		bus(1, 12'h000, 56);
		n = g_cnt;
		repeat (1000) @(posedge pclk);
		chk("gp_internal", g_cnt - n inside {[3:5]}, 1);
		bus(1, 12'h000, 48);
		n = g_cnt;
		fm.pulse(2, 8, 3);
		chk("gp_external", g_cnt - n inside {[3:5]}, 1);
		report_and_stop;
	end
endmodule // adc_trigger_pacer_counter_test
